/* File: sdi_core.sv */
// device-side init tracker, configuration register and burst column engine
// assumes the controller drives the command pins synchronously to core_clk
//
// Behaviour
// (R1) controller waits 100 us before real commands
// (R2) only idle commands during the 100 us
// (R3) controller raises cke during the wait
// (R4) precharge all leaves every bank idle
// (R5) controller idles for precharge_wait after precharge
// (R6) two or more refreshes, each refresh_cycle_wait
// (R7) refreshes may follow the configuration load
// (R8) configuration must be loaded before operation
// (R9) configuration load needs both bank bits zero
// (R10) configuration holds until the next load
// (R11) data outputs off once configuration loads
// (R12) controller idles config_load_wait after load
// (R13) field layout of operating_configuration bits
// (R14) controller drives address twelve low on load
// (R15) load only while all banks idle
// (R16) lengths 1,2,4,8; full row sequential only
// (R17) burst terminate ends a full row burst
// (R18) aligned block chosen by upper column bits
// (R19) full row burst wraps within the row
// (R20) normal operation needs operating mode zero
// (R21) write burst bit makes writes single location; full row mode repeats that column until terminate or precharge
// (R22) burst type selects sequential or interleaved
// (R23) read delay of two or three cycles
// (R24) each wait counted in clock cycles
`timescale 1ns/1ns
`default_nettype none

module sdi_core
    import sdi_pkg::*;
#(
    parameter int COL_W         = 9,
    parameter int POWERUP_CYC   = SDI_POWERUP_CYCLES,
    parameter int PRE_WAIT_NS   = 20,
    parameter int REF_WAIT_NS   = 66,
    parameter int CFG_WAIT_CYC  = 2
) (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rstn,
    // command pins
    input  wire sdi_pkg::sdi_cmd_t    cmd,
    // array side
    output var  logic [COL_W-1:0]     access_col,
    output var  logic                 access_valid,
    output var  logic                 access_write,
    output var  logic                 dq_oe,
    // status
    output var  logic [SDI_CFG_W-1:0] operating_configuration,
    output var  logic                 config_loaded,
    output var  logic                 banks_idle,
    output var  logic                 init_done,
    output var  logic                 seq_error
);
    import sdi_pkg::*;

    // ****************************************************
    // derived counts
    // ****************************************************
    localparam int PRE_CYC  = (PRE_WAIT_NS + SDI_CLK_PERIOD_NS - 1) / SDI_CLK_PERIOD_NS; // R24
    localparam int REF_CYC  = (REF_WAIT_NS + SDI_CLK_PERIOD_NS - 1) / SDI_CLK_PERIOD_NS; // R24
    localparam int CNT_W    = 16;
    if (COL_W < 3 || COL_W > 12 || POWERUP_CYC < 1 || POWERUP_CYC >= 65536 ||
        CFG_WAIT_CYC < 1 || PRE_WAIT_NS < 1 || REF_WAIT_NS < 1) begin : g_bad_param
        $error("sdi_core: parameter out of range");
    end

    // ****************************************************
    // command decode
    // ****************************************************
    sdi_op_t op;
    logic    op_idle;
    always_comb begin
        op = SDI_C_NOP;
        if (cmd.cke && !cmd.cs_n) begin
            case ({cmd.ras_n, cmd.cas_n, cmd.we_n})
                SDI_CODE_ACT: op = SDI_C_ACT;
                SDI_CODE_RD:  op = SDI_C_RD;
                SDI_CODE_WR:  op = SDI_C_WR;
                SDI_CODE_BT:  op = SDI_C_BT;
                SDI_CODE_PRE: op = SDI_C_PRE;
                SDI_CODE_REF: op = SDI_C_REF;
                SDI_CODE_CFG: op = SDI_C_CFG;
                default:      op = SDI_C_NOP;
            endcase
        end
        op_idle = (op == SDI_C_NOP);
    end

    // ****************************************************
    // init tracker
    // ****************************************************
    typedef enum {SDI_S_POWERUP, SDI_S_UNIDLE, SDI_S_WAIT, SDI_S_IDLE, SDI_S_OPEN} sdi_state_t;
    sdi_state_t             state_reg, state_next;
    logic [CNT_W-1:0]       wait_reg, wait_next;
    logic [1:0]             ref_reg, ref_next;
    logic                   loaded_reg, loaded_next;
    logic                   err_reg, err_next;
    logic                   ready_reg, ready_next;
    logic [SDI_CFG_W-1:0]   cfg_reg, cfg_next;
    always_comb begin
        state_next  = state_reg;
        wait_next   = wait_reg;
        ref_next    = ref_reg;
        loaded_next = loaded_reg;
        err_next    = err_reg;
        cfg_next    = cfg_reg;
        if (wait_reg != '0) begin
            wait_next = wait_reg - 1'b1;                                        // R24
        end
        case (state_reg)
            SDI_S_POWERUP: begin
                // idle commands only until the power-up count ends
                if (!op_idle) begin
                    err_next = 1'b1;                                            // R1
                end else if (wait_reg == '0) begin
                    state_next = SDI_S_UNIDLE;                                  // R2
                end
            end
            SDI_S_UNIDLE: begin
                if (op == SDI_C_PRE && cmd.addr[SDI_ALL_BANKS_BIT]) begin
                    state_next = SDI_S_WAIT;                                    // R4
                    wait_next  = CNT_W'(PRE_CYC - 1);                           // R5
                end else if (!op_idle) begin
                    err_next = 1'b1;
                end
            end
            SDI_S_WAIT: begin
                // any real command inside a wait is a protocol slip
                if (!op_idle) begin
                    err_next = 1'b1;                                            // R5 R6 R12
                end
                if (wait_reg == '0) begin
                    state_next = SDI_S_IDLE;
                end
            end
            SDI_S_IDLE: begin
                case (op)
                    SDI_C_REF: begin
                        if (ref_reg != 2'(SDI_REF_NEEDED)) begin
                            ref_next = ref_reg + 1'b1;                          // R6 R7
                        end
                        state_next = SDI_S_WAIT;
                        wait_next  = CNT_W'(REF_CYC - 1);
                    end
                    SDI_C_CFG: begin
                        if (cmd.ba != 2'h0 || cmd.addr[12]) begin
                            err_next = 1'b1;                                    // R9 R14
                        end else begin
                            cfg_next    = cmd.addr;                             // R10 R13
                            loaded_next = 1'b1;
                        end
                        state_next = SDI_S_WAIT;
                        wait_next  = CNT_W'(CFG_WAIT_CYC - 1);                  // R12
                    end
                    SDI_C_PRE: begin
                        state_next = SDI_S_WAIT;
                        wait_next  = CNT_W'(PRE_CYC - 1);
                    end
                    SDI_C_NOP: ;
                    SDI_C_ACT: begin
                        if (!ready_reg) begin
                            err_next = 1'b1;                                    // R8
                        end else begin
                            state_next = SDI_S_OPEN;
                        end
                    end
                    default: err_next = 1'b1;
                endcase
            end
            SDI_S_OPEN: begin
                // a row is open; only precharge returns to idle
                if (op == SDI_C_CFG || op == SDI_C_REF) begin
                    err_next = 1'b1;                                            // R15
                end else if (op == SDI_C_PRE) begin
                    state_next = SDI_S_WAIT;
                    wait_next  = CNT_W'(PRE_CYC - 1);
                end
            end
            default: state_next = SDI_S_POWERUP;
        endcase
        ready_next = loaded_next && (ref_next == 2'(SDI_REF_NEEDED))
                     && cfg_next[SDI_OPM_LSB +: 2] == SDI_OPM_NORMAL;           // R8 R20
    end
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_reg  <= SDI_S_POWERUP;
            wait_reg   <= CNT_W'(POWERUP_CYC - 1);                              // R1 R24
            ref_reg    <= 2'h0;
            loaded_reg <= 1'b0;
            err_reg    <= 1'b0;
            ready_reg  <= 1'b0;
            cfg_reg    <= SDI_CFG_RESET;
        end else begin
            state_reg  <= state_next;
            wait_reg   <= wait_next;
            ref_reg    <= ref_next;
            loaded_reg <= loaded_next;
            err_reg    <= err_next;
            ready_reg  <= ready_next;
            cfg_reg    <= cfg_next;
        end
    end

    // ****************************************************
    // configuration fields
    // ****************************************************
    logic [2:0]       bl_code;
    logic [2:0]       rdl_code;
    logic [COL_W-1:0] mask;
    logic             full_page;
    always_comb begin
        bl_code   = cfg_reg[SDI_BL_LSB +: 3];
        rdl_code  = cfg_reg[SDI_RDL_LSB +: 3];
        full_page = (bl_code == SDI_BL_PAGE);
        case (bl_code)                                                          // R16
            SDI_BL_2:    mask = COL_W'(1);
            SDI_BL_4:    mask = COL_W'(3);
            SDI_BL_8:    mask = COL_W'(7);
            SDI_BL_PAGE: mask = '1;
            default:     mask = '0;   // length one and reserved codes
        endcase
    end

    // ****************************************************
    // burst column engine
    // ****************************************************
    logic             act_reg, act_next;
    logic             wr_reg, wr_next;
    logic             il_reg, il_next;
    logic             page_reg, page_next;
    logic [COL_W-1:0] start_reg, start_next;
    logic [COL_W-1:0] msk_reg, msk_next;
    logic [COL_W-1:0] idx_reg, idx_next;
    logic [COL_W-1:0] col_reg, col_next;
    logic             vld_reg, vld_next;
    logic [COL_W-1:0] off;
    always_comb begin
        act_next   = act_reg;
        wr_next    = wr_reg;
        il_next    = il_reg;
        page_next  = page_reg;
        start_next = start_reg;
        msk_next   = msk_reg;
        idx_next   = idx_reg;
        vld_next   = 1'b0;
        col_next   = col_reg;
        off        = '0;
        if (state_reg == SDI_S_OPEN && (op == SDI_C_RD || op == SDI_C_WR)) begin
            // a new command cuts any burst in flight
            act_next   = 1'b1;
            wr_next    = (op == SDI_C_WR);
            il_next    = cfg_reg[SDI_BT_BIT] && !full_page;                     // R16 R22
            page_next  = full_page;
            start_next = cmd.addr[COL_W-1:0];
            msk_next   = (op == SDI_C_WR && cfg_reg[SDI_WB_BIT]) ? '0 : mask;   // R21
            idx_next   = '0;
        end else if (op == SDI_C_BT || op == SDI_C_PRE) begin
            act_next = 1'b0;                                                    // R17
        end
        if (act_next) begin
            off = il_next ? (start_next ^ idx_next)                             // R22
                          : (start_next + idx_next);
            col_next = (start_next & ~msk_next) | (off & msk_next);             // R18 R19
            vld_next = 1'b1;
            if (!page_next && idx_next == msk_next) begin
                act_next = 1'b0;
            end else begin
                idx_next = idx_next + 1'b1;   // full row runs on, wrapping
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            act_reg   <= 1'b0;
            wr_reg    <= 1'b0;
            il_reg    <= 1'b0;
            page_reg  <= 1'b0;
            start_reg <= '0;
            msk_reg   <= '0;
            idx_reg   <= '0;
            col_reg   <= '0;
            vld_reg   <= 1'b0;
        end else begin
            act_reg   <= act_next;
            wr_reg    <= wr_next;
            il_reg    <= il_next;
            page_reg  <= page_next;
            start_reg <= start_next;
            msk_reg   <= msk_next;
            idx_reg   <= idx_next;
            col_reg   <= col_next;
            vld_reg   <= vld_next;
        end
    end

    // ****************************************************
    // read output enable delay line
    // ****************************************************
    // access_valid for a read comes one edge after the command, so the
    // bus turns on read_delay edges after the command
    logic [1:0] oe_pipe_reg, oe_pipe_next;
    logic       rd_beat;
    always_comb begin
        rd_beat      = vld_reg && !wr_reg;
        oe_pipe_next = {oe_pipe_reg[0], rd_beat};
        if (op == SDI_C_CFG) begin
            oe_pipe_next = 2'h0;                                                // R11
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            oe_pipe_reg <= 2'h0;
        end else begin
            oe_pipe_reg <= oe_pipe_next;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    assign access_col              = col_reg;
    assign access_valid            = vld_reg;
    assign access_write            = wr_reg;
    assign dq_oe                   = (rdl_code == SDI_RDL_3) ? oe_pipe_reg[1]   // R23
                                                             : oe_pipe_reg[0];
    assign operating_configuration = cfg_reg;
    assign config_loaded           = loaded_reg;
    assign banks_idle              = (state_reg == SDI_S_IDLE);                 // R4
    assign init_done               = ready_reg;
    assign seq_error               = err_reg;

endmodule // sdi_core

`default_nettype wire

/* File: sdi_pkg.sv */
// package for the synchronous dram init tracker and configuration register
// assumes the command pins are sampled on the same core_clk as the controller
package sdi_pkg;

    // ****************************************************
    // command pins and decoded commands
    // ****************************************************
    typedef struct packed {
        logic        cke;
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [1:0]  ba;
        logic [12:0] addr;
    } sdi_cmd_t;

    typedef enum {
        SDI_C_NOP, SDI_C_ACT, SDI_C_RD, SDI_C_WR, SDI_C_BT,
        SDI_C_PRE, SDI_C_REF, SDI_C_CFG
    } sdi_op_t;

    // ras_n, cas_n, we_n codes with cs_n low
    localparam logic [2:0] SDI_CODE_NOP = 3'h7;
    localparam logic [2:0] SDI_CODE_ACT = 3'h3;
    localparam logic [2:0] SDI_CODE_RD  = 3'h5;
    localparam logic [2:0] SDI_CODE_WR  = 3'h4;
    localparam logic [2:0] SDI_CODE_BT  = 3'h6;
    localparam logic [2:0] SDI_CODE_PRE = 3'h2;
    localparam logic [2:0] SDI_CODE_REF = 3'h1;
    localparam logic [2:0] SDI_CODE_CFG = 3'h0;

    localparam int SDI_ALL_BANKS_BIT = 10;

    // ****************************************************
    // operating_configuration layout
    // ****************************************************
    localparam int SDI_CFG_W      = 13;
    localparam int SDI_BL_LSB     = 0;
    localparam int SDI_BT_BIT     = 3;
    localparam int SDI_RDL_LSB    = 4;
    localparam int SDI_OPM_LSB    = 7;
    localparam int SDI_WB_BIT     = 9;
    localparam logic [SDI_CFG_W-1:0] SDI_CFG_RESET = 13'h0000;

    localparam logic [2:0] SDI_BL_1    = 3'h0;
    localparam logic [2:0] SDI_BL_2    = 3'h1;
    localparam logic [2:0] SDI_BL_4    = 3'h2;
    localparam logic [2:0] SDI_BL_8    = 3'h3;
    localparam logic [2:0] SDI_BL_PAGE = 3'h7;
    localparam logic [2:0] SDI_RDL_2   = 3'h2;
    localparam logic [2:0] SDI_RDL_3   = 3'h3;
    localparam logic [1:0] SDI_OPM_NORMAL = 2'h0;

    // ****************************************************
    // timing
    // ****************************************************
    localparam int SDI_CLK_PERIOD_NS   = 8;
    localparam int SDI_POWERUP_WAIT_US = 100;
    localparam int SDI_POWERUP_CYCLES  =
        (SDI_POWERUP_WAIT_US * 1000 + SDI_CLK_PERIOD_NS - 1) / SDI_CLK_PERIOD_NS;
    localparam int SDI_REF_NEEDED      = 2;

endpackage

/* File: sdi_core_monitor.sv */
// concurrent checks on the ports of sdi_core
// assumes it is bound onto sdi_core and shares its COL_W
`timescale 1ns/1ns
`default_nettype none
module sdi_core_monitor
    import sdi_pkg::*;
#(
    parameter int COL_W = 9
) (
    // clock and reset
    input wire logic                 core_clk,
    input wire logic                 rstn,
    // command pins
    input wire sdi_pkg::sdi_cmd_t    cmd,
    // array side
    input wire logic [COL_W-1:0]     access_col,
    input wire logic                 access_valid,
    input wire logic                 access_write,
    input wire logic                 dq_oe,
    // status
    input wire logic [SDI_CFG_W-1:0] operating_configuration,
    input wire logic                 config_loaded,
    input wire logic                 banks_idle,
    input wire logic                 init_done,
    input wire logic                 seq_error
);
    // ********
    // decode
    // ********
    logic       take;
    logic [2:0] code;
    assign take = cmd.cke && !cmd.cs_n;
    assign code = {cmd.ras_n, cmd.cas_n, cmd.we_n};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_load;
        take && code == SDI_CODE_CFG;
    endsequence
    sequence s_good_load;
        s_load ##0 (cmd.ba == 2'h0 && !cmd.addr[12] && banks_idle);
    endsequence
    // a read that cuts a running read burst would keep the drive on early
    sequence s_rd_beat;
        !access_valid && take && code == SDI_CODE_RD ##1 access_valid;
    endsequence
    // ********
    // properties
    // ********
    property p_reset;
        disable iff (1'b0) !rstn |=> operating_configuration == 13'h0000 && !init_done
            && !config_loaded && !seq_error;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
    property p_load;
        s_good_load |=> operating_configuration == $past(cmd.addr);
    endproperty
    a_load: assert property (p_load) else $error("configuration not loaded");
    property p_bad_load;
        s_load ##0 (cmd.ba != 2'h0) |=> seq_error
            && operating_configuration == $past(operating_configuration);
    endproperty
    a_bad_load: assert property (p_bad_load) else $error("bank bits ignored on load");
    property p_hold;
        !(take && code == SDI_CODE_CFG) |=> $stable(operating_configuration);
    endproperty
    a_hold: assert property (p_hold) else $error("configuration changed");
    property p_dq_off;
        s_load |=> !dq_oe;
    endproperty
    a_dq_off: assert property (p_dq_off) else $error("data drive after load");
    property p_load_wait;
        s_good_load |=> !banks_idle;
    endproperty
    a_load_wait: assert property (p_load_wait) else $error("no wait after load");
    property p_pre_idle;
        take && code == SDI_CODE_PRE && cmd.addr[10] && !seq_error ##1 !seq_error
            |-> ##[0:8] banks_idle;
    endproperty
    a_pre_idle: assert property (p_pre_idle) else $error("banks not idle");
    property p_init;
        init_done |-> config_loaded && operating_configuration[8:7] == SDI_OPM_NORMAL;
    endproperty
    a_init: assert property (p_init) else $error("ready without load");
    property p_rd;
        s_rd_beat |-> access_col == $past(cmd.addr[COL_W-1:0]) && !access_write
            ##1 dq_oe == (operating_configuration[6:4] == SDI_RDL_2);
    endproperty
    a_rd: assert property (p_rd) else $error("first read beat wrong");
    property p_wr_single;
        take && code == SDI_CODE_WR && operating_configuration[9] ##1 access_valid
            |=> !access_valid;
    endproperty
    a_wr_single: assert property (p_wr_single) else $error("write not single");
    property p_sticky;
        seq_error |=> seq_error;
    endproperty
    a_sticky: assert property (p_sticky) else $error("error flag dropped");
endmodule // sdi_core_monitor

bind sdi_core sdi_core_monitor #(.COL_W(COL_W)) u_sdi_core_monitor (.core_clk, .rstn, .cmd,
    .access_col, .access_valid, .access_write, .dq_oe, .operating_configuration,
    .config_loaded, .banks_idle, .init_done, .seq_error);
`default_nettype wire

/* File: sdi_ctl.sv */
// controller model driving the command pins of sdi_core
// assumes the caller spaces commands by the wait it passes
`timescale 1ns/1ns
`default_nettype none
module sdi_ctl
    import sdi_pkg::*;
(
    // clock
    input  wire logic         core_clk,
    // command pins
    output var  sdi_pkg::sdi_cmd_t cmd
);
    // ********
    // drivers
    // ********
    initial begin
        cmd = {1'b0, 1'b1, SDI_CODE_NOP, 2'h0, 13'h0000};
    end
    task automatic cke_up();
        @(posedge core_clk);
        cmd <= {1'b1, 1'b1, SDI_CODE_NOP, 2'h0, 13'h0000};
    endtask
    // only idle commands while waiting
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // one command for one cycle, then n idle cycles
    task automatic send(input logic [2:0] c, input logic [1:0] ba, input logic [12:0] a,
                        input int n);
        @(posedge core_clk);
        cmd <= {1'b1, 1'b0, c, ba, a};
        @(posedge core_clk);
        cmd <= {1'b1, 1'b0, SDI_CODE_NOP, 2'h0, 13'h0000};
        idle(n);
    endtask
endmodule // sdi_ctl
`default_nettype wire

/* File: sdi_core_test.sv */
// self-checking bench for sdi_core
// assumes sdi_ctl drives the pins and the monitor is bound
`timescale 1ns/1ns
`default_nettype none
module sdi_core_test;
    import sdi_pkg::*;
    // ********
    // harness
    // ********
    localparam int PU = 20;
    logic           core_clk;
    logic           rstn;
    sdi_cmd_t       cmd;
    logic [8:0]     access_col;
    logic           access_valid, access_write, dq_oe;
    logic [12:0]    operating_configuration;
    logic           config_loaded, banks_idle, init_done, seq_error;
    logic [12:0]    cur;
    int             err_count, n_compared;
    sdi_ctl u_sdi_ctl (.core_clk, .cmd);
    sdi_core #(.COL_W(9), .POWERUP_CYC(PU)) u_sdi_core (.core_clk, .rstn, .cmd,
        .access_col, .access_valid, .access_write, .dq_oe, .operating_configuration,
        .config_loaded, .banks_idle, .init_done, .seq_error);
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // ********
    // helpers
    // ********
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    function automatic logic [12:0] mk(input logic [2:0] bl, input logic bt,
                                       input logic [2:0] rdl, input logic wb);
        return {3'h0, wb, SDI_OPM_NORMAL, rdl, bt, bl};
    endfunction
    function automatic logic [8:0] col_at(input logic [8:0] st, input int i);
        logic [8:0] m;
        m = (cur[2:0] == SDI_BL_PAGE) ? 9'h1ff : 9'((1 << cur[2:0]) - 1);
        return (st & ~m) | ((cur[3] ? (st ^ 9'(i)) : (st + 9'(i))) & m);
    endfunction
    task automatic load(input logic [12:0] c);
        u_sdi_ctl.send(SDI_CODE_CFG, 2'h0, c, 3);
        cur = c;
        chk(operating_configuration, c);
        chk(dq_oe, 1'b0);
    endtask
    task automatic burst(input logic [2:0] code, input logic [8:0] st, input int n);
        logic wr;
        wr = (code == SDI_CODE_WR);
        u_sdi_ctl.send(code, 2'h0, {4'h0, st}, 0);
        // beat i stands from the i-th edge after the command edge
        for (int i = 0; i < n; i++) begin
            if (i > 0) begin
                @(posedge core_clk);
                #1;
            end
            chk(access_valid, 1'b1);
            chk(access_col, col_at(st, i));
            chk(access_write, wr);
            if (!wr) chk(dq_oe, i + 1 >= int'(cur[6:4]));
        end
        if (cur[2:0] != SDI_BL_PAGE) begin
            @(posedge core_clk);
            #1;
            chk(access_valid, 1'b0);
        end
    endtask
    task automatic init_seq(input logic [12:0] c);
        u_sdi_ctl.cke_up();
        u_sdi_ctl.idle(PU + 2);
        u_sdi_ctl.send(SDI_CODE_PRE, 2'h0, 13'h0400, 4);
        chk(banks_idle, 1'b1);
        load(c);
        for (int i = 0; i < 2; i++) begin
            chk(init_done, 1'b0);
            u_sdi_ctl.send(SDI_CODE_REF, 2'h0, 13'h0000, 10);
        end
        chk(init_done, 1'b1);
        chk(config_loaded, 1'b1);
        chk(seq_error, 1'b0);
    endtask
    // ********
    // tests
    // ********
    initial begin
        err_count = 0;
        n_compared = 0;
        rstn = 1'b0;
        cur = 13'h0000;
        repeat (6) @(posedge core_clk);
        #1;
        chk({access_valid, dq_oe, config_loaded, banks_idle, init_done, seq_error}, 16'h0000);
        chk(operating_configuration, SDI_CFG_RESET);
        @(posedge core_clk);
        rstn <= 1'b1;
        u_sdi_ctl.send(SDI_CODE_PRE, 2'h0, 13'h0400, 1);
        chk(seq_error, 1'b1);
        // second reset in mid-run clears the sticky error
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        init_seq(mk(SDI_BL_4, 1'b0, SDI_RDL_2, 1'b0));
        u_sdi_ctl.send(SDI_CODE_ACT, 2'h0, 13'h0000, 2);
        burst(SDI_CODE_RD, 9'h005, 4);
        u_sdi_ctl.send(SDI_CODE_PRE, 2'h0, 13'h0400, 4);
        load(mk(SDI_BL_8, 1'b1, SDI_RDL_3, 1'b1));
        u_sdi_ctl.send(SDI_CODE_ACT, 2'h0, 13'h0000, 2);
        burst(SDI_CODE_RD, 9'h005, 8);
        burst(SDI_CODE_WR, 9'h00d, 1);
        u_sdi_ctl.send(SDI_CODE_PRE, 2'h0, 13'h0400, 4);
        load(mk(SDI_BL_PAGE, 1'b0, SDI_RDL_2, 1'b0));
        u_sdi_ctl.send(SDI_CODE_ACT, 2'h0, 13'h0000, 2);
        burst(SDI_CODE_RD, 9'h1fe, 4);
        u_sdi_ctl.send(SDI_CODE_BT, 2'h0, 13'h0000, 2);
        chk(access_valid, 1'b0);
        u_sdi_ctl.send(SDI_CODE_PRE, 2'h0, 13'h0400, 4);
        u_sdi_ctl.send(SDI_CODE_CFG, 2'h1, 13'h0022, 3);
        chk(seq_error, 1'b1);
        chk(operating_configuration, cur);
        print_verdict();
    end
    // the whole run is under 150 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        print_verdict();
    end
endmodule // sdi_core_test
`default_nettype wire
